//--- include/oc_resp_pkg.sv
// constants, types and register map of the input overcurrent fault reaction block
package oc_resp_pkg;
    // register indices (no printed offset for this block)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // control field positions
    localparam int RESP_LSB = 6;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_LSB = 0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;
    // interrupt bits
    localparam int IRQ_SHUT = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_LATCH = 2;
    localparam int IRQ_W = 3;
    // timing: 40 MHz clock, 1 ms tick
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // delay tables in ms, indexed by delay code
    localparam logic [10:0] DELAY1_MS [8] = '{11'd10, 11'd20, 11'd40, 11'd80,
        11'd160, 11'd320, 11'd640, 11'd1280};
    localparam logic [11:0] DELAY2_MS [8] = '{12'd252, 12'd558, 12'd924, 12'd1260,
        12'd1596, 12'd1932, 12'd2268, 12'd2604};

    typedef enum logic [1:0] {
        RESP_IGNORE = 2'b00,
        RESP_DELAYED = 2'b01,
        RESP_IMMEDIATE = 2'b10,
        RESP_HOLD = 2'b11
    } resp_t;

    typedef struct packed {
        resp_t resp;
        logic [2:0] retries;
        logic [2:0] delay;
    } ctrl_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_WAIT1 = 3'b001,
        ST_OFF = 3'b010,
        ST_RESTART = 3'b011,
        ST_HOLD = 3'b100,
        ST_LATCHED = 3'b101
    } state_t;
endpackage

//--- rtl/ms_ticker.sv
// divider giving a one-cycle pulse every millisecond
`timescale 1ns/10ps
module ms_ticker import oc_resp_pkg::*; #(
    parameter int CYCLES = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // tick out
    output logic tick
);
    // a one-cycle period would leave the count stuck at zero
    if (CYCLES < 2) begin : g_bad_cycles
        $error("ms_ticker: CYCLES must be at least 2");
    end

    logic [31:0] cnt_ff;

    // free-running count, pulse on wrap
    always_ff @(posedge clk) begin
        if (reset || cnt_ff == 32'(CYCLES - 1)) begin
            cnt_ff <= 32'h0000_0000;
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    assign tick = (cnt_ff == 32'(CYCLES - 1));
endmodule // ms_ticker

//--- rtl/oc_fault_response.sv
// input overcurrent fault reaction state machine with register port
`timescale 1ns/10ps
module oc_fault_response import oc_resp_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fault sense and power stage
    input wire logic oc_fault,
    input wire logic bias_lost,
    output logic output_enable,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // interrupt
    output logic irq
);
    // refuse tick lengths the divider cannot produce
    if (TICK_CYC < 2) begin : g_bad_tick
        $error("oc_fault_response: TICK_CYC must be at least 2");
    end
    // the read mux packs the sticky bits into one byte
    if (IRQ_W > 8) begin : g_bad_irq_w
        $error("oc_fault_response: IRQ_W must fit the 8-bit data port");
    end

    logic tick;
    ctrl_t ctrl_ff;
    logic [7:0] mask_ff;
    logic [IRQ_W-1:0] irq_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    state_t state_ff;
    state_t nxt_state;
    logic [11:0] timer_ff;
    logic [11:0] nxt_timer;
    logic [2:0] attempts_ff;
    logic [2:0] nxt_attempts;
    logic [IRQ_W-1:0] ev;
    logic clear_all;
    logic retries_left;

    ms_ticker #(.CYCLES(TICK_CYC)) u_tick (
        .clk(clk),
        .reset(reset),
        .tick(tick)
    );

    // bias loss acts like a reset of the latched state
    assign clear_all = reset || bias_lost;
    assign retries_left = (ctrl_ff.retries == RETRY_ENDLESS)
        || (attempts_ff < ctrl_ff.retries);

    // control register written by software
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_ff <= ctrl_t'(CTRL_RESET);
        end else if (reg_write && reg_addr == ADDR_CTRL) begin
            ctrl_ff <= ctrl_t'(reg_wdata);
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_ff <= MASK_RESET;
        end else if (reg_write && reg_addr == ADDR_MASK) begin
            mask_ff <= reg_wdata;
        end
    end

    // reaction sequencer, combinational part
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_attempts = attempts_ff;
        ev = '0;
        if (tick && timer_ff != 12'h000) begin
            nxt_timer = timer_ff - 12'h001;
        end
        unique case (state_ff)
            ST_RUN: begin
                nxt_attempts = 3'h0;
                if (oc_fault) begin
                    unique case (ctrl_ff.resp)
                        RESP_IGNORE: nxt_state = ST_RUN;
                        RESP_DELAYED: begin
                            nxt_state = ST_WAIT1;
                            nxt_timer = 12'(DELAY1_MS[ctrl_ff.delay]);
                        end
                        RESP_IMMEDIATE: begin
                            nxt_state = ST_OFF;
                            nxt_timer = DELAY2_MS[ctrl_ff.delay];
                            ev[IRQ_SHUT] = 1'b1;
                        end
                        RESP_HOLD: begin
                            nxt_state = ST_HOLD;
                            ev[IRQ_SHUT] = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAIT1: begin
                // fault gone before the delay ran out: keep running
                if (!oc_fault) begin
                    nxt_state = ST_RUN;
                end else if (timer_ff == 12'h000) begin
                    nxt_state = ST_OFF;
                    nxt_timer = DELAY2_MS[ctrl_ff.delay];
                    ev[IRQ_SHUT] = 1'b1;
                end
            end
            ST_OFF: begin
                if (timer_ff == 12'h000) begin
                    if (retries_left) begin
                        nxt_state = ST_RESTART;
                        ev[IRQ_RESTART] = 1'b1;
                        if (attempts_ff != RETRY_ENDLESS) begin
                            nxt_attempts = attempts_ff + 3'h1;
                        end
                    end else if (oc_fault) begin
                        nxt_state = ST_LATCHED;
                        ev[IRQ_LATCH] = 1'b1;
                    end else begin
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_RESTART: begin
                // one cycle with output on to probe the fault
                if (oc_fault) begin
                    nxt_state = ST_OFF;
                    nxt_timer = DELAY2_MS[ctrl_ff.delay];
                    ev[IRQ_SHUT] = 1'b1;
                end else begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!oc_fault) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_LATCHED: begin
                nxt_state = ST_LATCHED;
            end
            default: nxt_state = ST_LATCHED;
        endcase
    end

    // sequencer state; only reset or bias loss leaves the latched state
    always_ff @(posedge clk) begin
        if (clear_all) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // millisecond down-counter for both delays
    always_ff @(posedge clk) begin
        if (clear_all) begin
            timer_ff <= 12'h000;
        end else begin
            timer_ff <= nxt_timer;
        end
    end

    // restart attempt count, also visible to software
    always_ff @(posedge clk) begin
        if (clear_all) begin
            attempts_ff <= 3'h0;
        end else begin
            attempts_ff <= nxt_attempts;
        end
    end

    // output stays on while running, waiting or probing
    assign output_enable = (state_ff == ST_RUN) || (state_ff == ST_WAIT1)
        || (state_ff == ST_RESTART);

    // sticky events, one flop per bit; set wins so no event is lost to a clear
    for (genvar b = 0; b < IRQ_W; b++) begin : g_sticky
        always_ff @(posedge clk) begin
            if (reset) begin
                irq_ff[b] <= 1'b0;
            end else if (ev[b]) begin
                irq_ff[b] <= 1'b1;
            end else if (reg_write && reg_addr == ADDR_IRQ && reg_wdata[b]) begin
                irq_ff[b] <= 1'b0;
            end
        end
    end

    assign irq = |(irq_ff & mask_ff[IRQ_W-1:0]);

    // read mux; unmapped indices read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_CTRL: nxt_rdata = ctrl_ff;
                ADDR_STATUS: nxt_rdata = {3'h0, oc_fault, output_enable, state_ff};
                ADDR_IRQ: nxt_rdata = {{(8-IRQ_W){1'b0}}, irq_ff};
                ADDR_MASK: nxt_rdata = mask_ff;
                ADDR_COUNT: nxt_rdata = {5'h00, attempts_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule // oc_fault_response

//--- sim/oc_fault_response_sva.sv
// assertion checker for the overcurrent reaction block
`timescale 1ns/10ps
module oc_fault_response_sva import oc_resp_pkg::*; #(
    parameter int TICK_CYC = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched ports
    input wire logic oc_fault,
    input wire logic bias_lost,
    input wire logic output_enable,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] ctrl_ff;
    logic [15:0] run_ff;
    logic [15:0] off_ff;
    // shadow of the control register, taken from bus writes
    always_ff @(posedge clk) begin
        if (reset) ctrl_ff <= CTRL_RESET;
        else if (reg_write && reg_addr == ADDR_CTRL) ctrl_ff <= reg_wdata;
    end
    // cycles run with fault present, and cycles with output off
    always_ff @(posedge clk) begin
        run_ff <= (reset || !(oc_fault && output_enable)) ? 16'h0000 : run_ff + 16'h0001;
        off_ff <= (reset || output_enable) ? 16'h0000 : off_ff + 16'h0001;
    end
    property p_ignore;
        ctrl_ff[7:6] == 2'b00 && output_enable && $past(output_enable) |=> output_enable;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore mode dropped output");
    property p_immed;
        ctrl_ff[7:6] == 2'b10 && oc_fault && output_enable && $past(output_enable)
            && !bias_lost |=> !output_enable;
    endproperty
    a_immed: assert property (p_immed) else $error("no immediate shutdown");
    property p_hold;
        ctrl_ff[7:6] == 2'b11 && oc_fault && !output_enable && !bias_lost |=> !output_enable;
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode resumed early");
    property p_rdata;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside read cycle");
    property p_ctrl_rd;
        reg_read && reg_addr == ADDR_CTRL |=> reg_rdata == ctrl_ff;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_delay1;
        ctrl_ff == 8'h40 && oc_fault && run_ff > 0 && run_ff < 8 * TICK_CYC |-> output_enable;
    endproperty
    a_delay1: assert property (p_delay1) else $error("delayed shutdown too early");
    property p_gap;
        $rose(output_enable) && ctrl_ff[7:6] == 2'b10 && ctrl_ff[2:0] == 3'h0
            && !$past(bias_lost) |-> off_ff >= 251 * TICK_CYC && off_ff <= 252 * TICK_CYC + 4;
    endproperty
    a_gap: assert property (p_gap) else $error("restart spacing wrong");
    property p_bias;
        bias_lost |=> output_enable;
    endproperty
    a_bias: assert property (p_bias) else $error("bias loss kept output off");
    c_shut: cover property ($fell(output_enable));
    c_irq: cover property ($rose(irq));
    c_bias: cover property (bias_lost && !output_enable);
endmodule // oc_fault_response_sva

//--- sim/test_oc_fault_response.sv
// self-checking bench for the overcurrent reaction block
`timescale 1ns/10ps
module test_oc_fault_response import oc_resp_pkg::*;;
    localparam int T = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic oc_fault = 1'b0;
    logic bias_lost = 1'b0;
    logic output_enable;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int n = 0;
    // rows: address, value written, value read back
    logic [3:0] ra [5] = '{ADDR_CTRL, ADDR_MASK, 4'hF, ADDR_STATUS, ADDR_COUNT};
    logic [7:0] rw [5] = '{8'hC5, 8'h07, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] rx [5] = '{8'hC5, 8'h07, 8'h00, 8'h08, 8'h00};
    always #12.5 clk = ~clk;
    oc_fault_response #(.TICK_CYC(T)) DUT (.clk(clk), .reset(reset), .oc_fault(oc_fault),
        .bias_lost(bias_lost), .output_enable(output_enable), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq));
    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    // edges until output_enable reaches v, capped at lim
    task automatic wt(input logic v, input int lim);
        #1 n = 0;
        while (output_enable !== v && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // hang guard, well above the longest sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_MASK, MASK_RESET);
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], rx[i]);
        end
        // ignore mode rides through the fault
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MASK, 8'h07);
        @(posedge clk) oc_fault <= 1'b1;
        wt(1'b0, 30);
        chk("ignore", 30, n[15:0]);
        @(posedge clk) oc_fault <= 1'b0;
        rd(ADDR_IRQ, 8'h00);
        // immediate, one retry, fault never goes away
        wr(ADDR_CTRL, 8'h88);
        @(posedge clk) oc_fault <= 1'b1;
        wt(1'b0, 10);
        chk("shut", 1, n[15:0]);
        chk("irq", 1, irq);
        wt(1'b1, 1100);
        chk("gap", 1, n >= 251 * T - 2 && n <= 252 * T + 4);
        rd(ADDR_COUNT, 8'h01);
        wt(1'b1, 1100);
        chk("latch", 1100, n[15:0]);
        rd(ADDR_IRQ, 8'h07);
        @(posedge clk) oc_fault <= 1'b0;
        wt(1'b1, 50);
        chk("latched", 50, n[15:0]);
        @(posedge clk) bias_lost <= 1'b1;
        @(posedge clk) bias_lost <= 1'b0;
        wt(1'b1, 5);
        chk("bias", 1, output_enable);
        rd(ADDR_COUNT, 8'h00);
        wr(ADDR_IRQ, 8'h07);
        rd(ADDR_IRQ, 8'h00);
        // delayed mode with interrupt masked
        wr(ADDR_MASK, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        @(posedge clk) oc_fault <= 1'b1;
        wt(1'b0, 100);
        chk("delay1", 1, n >= 9 * T && n <= 10 * T + 4);
        chk("masked", 0, irq);
        @(posedge clk) oc_fault <= 1'b0;
        wt(1'b1, 1100);
        chk("rerun", 1, n < 1100);
        wr(ADDR_MASK, 8'h01);
        #1 chk("unmask", 1, irq);
        wr(ADDR_IRQ, 8'h07);
        #1 chk("clear", 0, irq);
        // hold mode stays off while the fault lasts
        wr(ADDR_CTRL, 8'hC0);
        @(posedge clk) oc_fault <= 1'b1;
        wt(1'b0, 10);
        chk("hold", 1, n[15:0]);
        wt(1'b1, 300);
        chk("held", 300, n[15:0]);
        @(posedge clk) oc_fault <= 1'b0;
        wt(1'b1, 10);
        chk("resume", 1, n <= 3);
        final_report;
    end
endmodule // test_oc_fault_response
bind oc_fault_response oc_fault_response_sva #(.TICK_CYC(TICK_CYC)) u_sva (.clk(clk),
    .reset(reset), .oc_fault(oc_fault), .bias_lost(bias_lost),
    .output_enable(output_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
